//--- dv/gec_regs_tb_top.sv
// self-checking bench of the drawing engine register bank
`timescale 1ns/1ps
`default_nettype none
module gec_regs_tb_top
    import gec_pkg::*;
;
    // ================================================================
    // signals and bookkeeping
    localparam int          CYCLE_LIMIT = 3000;
    localparam logic [15:0] RW_OFF [9]  = '{GEC_OFF_DEST_Y, GEC_OFF_DEST_X, GEC_OFF_ERR,
        GEC_OFF_MAJOR, GEC_OFF_BG, GEC_OFF_FG, GEC_OFF_WMASK, GEC_OFF_RMASK, GEC_OFF_CMP};
    localparam logic [31:0] RW_MSK [9]  = '{32'h3fff, 32'h3fff, 32'h3fff, 32'hfff,
        32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff};
    localparam logic [3:0]  MF_IDX [4]  = '{GEC_MF_MINOR, GEC_MF_TOP, GEC_MF_LEFT, GEC_MF_MISC};
    logic        clk_i;
    logic        resetn_i;
    logic        psel_i;
    logic        penable_i;
    logic        pwrite_i;
    logic [15:0] paddr_i;
    logic [31:0] pwdata_i;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic [12:0] fifo_free_i;
    logic        engine_busy_i;
    logic        fifo_empty_i;
    gec_cmd_t    cmd_o;
    logic        cmd_valid_o;
    gec_vec_t    vec1_o;
    gec_vec_t    vec2_o;
    logic        vec_valid_o;
    logic [13:0] dest_y_o;
    logic [13:0] dest_x_o;
    logic [13:0] err_term_o;
    logic [11:0] major_o;
    logic [11:0] minor_o;
    logic [11:0] clip_top_o;
    logic [11:0] clip_left_o;
    logic [11:0] mf_misc_o;
    logic [6:0]  bg_mix_o;
    logic [6:0]  fg_mix_o;
    logic [31:0] pix_new_i;
    logic [31:0] bitmap_i;
    logic [31:0] pix_wr_o;
    logic [31:0] pix_rd_o;
    logic        cmp_match_o;
    logic [31:0] bg_colour_o;
    logic [31:0] fg_colour_o;
    logic [31:0] rd_data;
    logic        rd_err;
    logic [31:0] seed;
    int          err_total   = 0;
    int          comparisons = 0;
    int          cycles      = 0;
    int          cmd_pulses  = 0;
    int          vec_pulses  = 0;

    gec_regs dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .fifo_free_i(fifo_free_i),
        .engine_busy_i(engine_busy_i), .fifo_empty_i(fifo_empty_i), .cmd_o(cmd_o),
        .cmd_valid_o(cmd_valid_o), .vec1_o(vec1_o), .vec2_o(vec2_o), .vec_valid_o(vec_valid_o),
        .dest_y_o(dest_y_o), .dest_x_o(dest_x_o), .err_term_o(err_term_o), .major_o(major_o),
        .minor_o(minor_o), .clip_top_o(clip_top_o), .clip_left_o(clip_left_o),
        .mf_misc_o(mf_misc_o), .bg_mix_o(bg_mix_o), .fg_mix_o(fg_mix_o), .pix_new_i(pix_new_i),
        .bitmap_i(bitmap_i), .pix_wr_o(pix_wr_o), .pix_rd_o(pix_rd_o),
        .cmp_match_o(cmp_match_o), .bg_colour_o(bg_colour_o), .fg_colour_o(fg_colour_o));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // ================================================================
    // monitors: pulse counts reveal both missing and stretched strobes
    always @(posedge clk_i) begin
        cmd_pulses <= cmd_pulses + int'(cmd_valid_o);
        vec_pulses <= vec_pulses + int'(vec_valid_o);
        cycles     <= cycles + 1;
        if (cycles == CYCLE_LIMIT) begin
            err_total++;
            report_and_stop();
        end
    end

    // ================================================================
    // helpers
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; releases only after pready was sampled high
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= wr;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1) @(posedge clk_i);
        rd_data = prdata_o;
        rd_err  = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask

    function automatic logic [31:0] port_val(input int i);
        case (i)
            0: return {18'h0, dest_y_o};
            1: return {18'h0, dest_x_o};
            2: return {18'h0, err_term_o};
            3: return {20'h0, major_o};
            4: return bg_colour_o;
            default: return fg_colour_o;
        endcase
    endfunction

    function automatic logic [31:0] status_exp(input logic [12:0] f, input logic b, input logic e);
        return {16'h0, f[12:8], e, b, 1'b0, f[7:0]};
    endfunction

    // ================================================================
    // main sequence
    initial begin
        logic [31:0] w;
        logic [31:0] pn;
        logic [31:0] bm;
        logic [12:0] ff;
        logic [11:0] mv [4];
        logic [31:0] wv [9];
        logic [31:0] rb [6];
        seed = 32'h3b16;
        {resetn_i, psel_i, penable_i, pwrite_i, engine_busy_i, fifo_empty_i} = '0;
        {paddr_i, pwdata_i, fifo_free_i, pix_new_i, bitmap_i} = '0;
        repeat (11) @(posedge clk_i);
        @(negedge clk_i);
        check({31'h0, pready_o}, 32'h1);
        check({18'h0, dest_y_o}, 32'h0);
        @(posedge clk_i);
        resetn_i <= 1'b1;
        // bank starts disabled: write dropped, read refused
        apb(1'b1, GEC_OFF_DEST_Y, 32'h1234);
        apb(1'b0, GEC_OFF_DEST_Y, 32'h0);
        check({31'h0, rd_err}, 32'h1);
        apb(1'b1, GEC_OFF_SYSCFG, 32'h1);
        apb(1'b0, GEC_OFF_DEST_Y, 32'h0);
        check(rd_data, 32'h0);
        for (int i = 0; i < 9; i++) begin
            wv[i] = $random(seed);
            apb(1'b1, RW_OFF[i], wv[i]);
            @(negedge clk_i);
            if (i < 6) check(port_val(i), wv[i] & RW_MSK[i]);
            apb(1'b0, RW_OFF[i], 32'h0);
            check(rd_data, wv[i] & RW_MSK[i]);
        end
        for (int k = 0; k < 6; k++) begin
            ff = (k == 0) ? 13'h1fff : 13'($random(seed));
            @(posedge clk_i);
            fifo_free_i   <= ff;
            engine_busy_i <= k[0];
            fifo_empty_i  <= k[1];
            apb(1'b0, GEC_OFF_STATUS, 32'h0);
            check(rd_data, status_exp(ff, k[0], k[1]));
        end
        // every command type once; bit 0 always written as one
        for (int k = 0; k < 8; k++) begin
            w = {16'h0, 3'(k), 13'($random(seed))} | 32'h1;
            apb(1'b1, GEC_OFF_STATUS, w);
            @(negedge clk_i);
            check(32'(cmd_o) & 32'hf7ff, w & 32'hf7ff);
            check({31'h0, cmd_o.skip_last}, {31'h0, w[2]});
        end
        for (int k = 0; k < 4; k++) begin
            w = $random(seed);
            apb(1'b1, GEC_OFF_SSV, w);
            @(negedge clk_i);
            check({16'h0, vec2_o, vec1_o}, {16'h0, w[15:0]});
        end
        apb(1'b0, GEC_OFF_SSV, 32'h0);
        check(rd_data, 32'h0);
        w = $random(seed);
        apb(1'b1, GEC_OFF_BMIX, w);
        apb(1'b1, GEC_OFF_FMIX, ~w);
        @(negedge clk_i);
        check({25'h0, bg_mix_o}, {25'h0, w[6:5], 1'b0, w[3:0]});
        check({25'h0, fg_mix_o}, {25'h0, ~w[6:5], 1'b0, ~w[3:0]});
        // last two cases: bitmap one bit off the compare colour, then equal
        for (int k = 0; k < 4; k++) begin
            pn = $random(seed);
            bm = (k == 3) ? wv[8] : (k == 2) ? wv[8] ^ 32'h1 : $random(seed);
            @(posedge clk_i);
            pix_new_i <= pn;
            bitmap_i  <= bm;
            @(posedge clk_i);
            @(negedge clk_i);
            check(pix_wr_o, (pn & wv[6]) | (bm & ~wv[6]));
            check(pix_rd_o, bm & wv[7]);
            check({31'h0, cmp_match_o}, {31'h0, bm == wv[8]});
        end
        for (int k = 0; k < 4; k++) begin
            mv[k] = 12'($random(seed));
            apb(1'b1, GEC_OFF_MF, {16'h0, MF_IDX[k], mv[k]});
        end
        // an unused index must not disturb the others
        apb(1'b1, GEC_OFF_MF, {16'h0, 4'h7, 12'hfff});
        @(negedge clk_i);
        check({20'h0, minor_o}, {20'h0, mv[0]});
        check({20'h0, clip_top_o}, {20'h0, mv[1]});
        check({20'h0, clip_left_o}, {20'h0, mv[2]});
        check({20'h0, mf_misc_o}, {20'h0, mv[3]});
        rb = '{{20'h0, mv[0]}, {20'h0, mv[1]}, {20'h0, mv[2]}, {20'h0, mv[3]},
               wv[3] & 32'hfff, 32'h0};
        for (int s = 0; s < 6; s++) begin
            apb(1'b1, GEC_OFF_MF, {16'h0, GEC_MF_RDSEL, 9'h0, 3'(s)});
            apb(1'b0, GEC_OFF_MF, 32'h0);
            check(rd_data, rb[s]);
        end
        apb(1'b0, 16'h8000, 32'h0);
        check({31'h0, rd_err}, 32'h1);
        apb(1'b1, GEC_OFF_SYSCFG, 32'h0);
        // a write while disabled must leave the colour as it was
        apb(1'b1, GEC_OFF_FG, ~wv[5]);
        apb(1'b0, GEC_OFF_BG, 32'h0);
        check({rd_data[30:0], rd_err}, 32'h1);
        check(fg_colour_o, wv[5]);
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        check(32'(cmd_pulses), 32'h8);
        check(32'(vec_pulses), 32'h4);
        report_and_stop();
    end
endmodule
`default_nettype wire

//--- hdl/gec_regs.sv
// apb register bank of the 2d drawing engine
`timescale 1ns/1ps
`default_nettype none
module gec_regs
    import gec_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [15:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output var  logic [31:0] prdata_o,
    output var  logic        pready_o,
    output var  logic        pslverr_o,
    // engine state
    input  wire logic [12:0] fifo_free_i,
    input  wire logic        engine_busy_i,
    input  wire logic        fifo_empty_i,
    // command and stroke strobes
    output var  gec_cmd_t    cmd_o,
    output var  logic        cmd_valid_o,
    output var  gec_vec_t    vec1_o,
    output var  gec_vec_t    vec2_o,
    output var  logic        vec_valid_o,
    // geometry and mixes
    output var  logic [13:0] dest_y_o,
    output var  logic [13:0] dest_x_o,
    output var  logic [13:0] err_term_o,
    output var  logic [11:0] major_o,
    output var  logic [11:0] minor_o,
    output var  logic [11:0] clip_top_o,
    output var  logic [11:0] clip_left_o,
    output var  logic [11:0] mf_misc_o,
    output var  logic [6:0]  bg_mix_o,
    output var  logic [6:0]  fg_mix_o,
    // pixel datapath
    input  wire logic [31:0] pix_new_i,
    input  wire logic [31:0] bitmap_i,
    output var  logic [31:0] pix_wr_o,
    output var  logic [31:0] pix_rd_o,
    output var  logic        cmp_match_o,
    output var  logic [31:0] bg_colour_o,
    output var  logic [31:0] fg_colour_o
);
    // ================================================================
    // bus decode
    logic        setup;
    logic        access;
    logic        wr;
    logic        en_reg;
    logic [2:0]  rdsel_reg;
    logic [31:0] wmask_reg;
    logic [31:0] rmask_reg;
    logic [31:0] cmp_reg;
    logic [31:0] prdata_next;
    logic        err_next;

    assign setup    = psel_i & ~penable_i;
    assign access   = psel_i & penable_i;
    assign wr       = access & pwrite_i & en_reg;
    // read data is latched in setup, so the answer needs no wait
    assign pready_o = 1'b1;

    function automatic logic [31:0] rb_mux(input logic [2:0] sel);
        case (sel)
            GEC_RB_MINOR: rb_mux = {20'h0, minor_o};
            GEC_RB_TOP:   rb_mux = {20'h0, clip_top_o};
            GEC_RB_LEFT:  rb_mux = {20'h0, clip_left_o};
            GEC_RB_MISC:  rb_mux = {20'h0, mf_misc_o};
            GEC_RB_MAJOR: rb_mux = {20'h0, major_o};
            default:      rb_mux = 32'h0;
        endcase
    endfunction

    always_comb begin
        prdata_next = GEC_RST;
        err_next    = ~en_reg;
        case (paddr_i)
            GEC_OFF_SYSCFG: begin
                prdata_next = {31'h0, en_reg};
                err_next    = 1'b0;
            end
            GEC_OFF_DEST_Y: prdata_next = {18'h0, dest_y_o};
            GEC_OFF_DEST_X: prdata_next = {18'h0, dest_x_o};
            GEC_OFF_ERR:    prdata_next = {18'h0, err_term_o};
            GEC_OFF_MAJOR:  prdata_next = {20'h0, major_o};
            GEC_OFF_STATUS: prdata_next = {16'h0, fifo_free_i[12:8],
                fifo_empty_i, engine_busy_i, 1'b0,
                fifo_free_i[7:0]};
            GEC_OFF_SSV:    prdata_next = GEC_RST;
            GEC_OFF_BG:     prdata_next = bg_colour_o;
            GEC_OFF_FG:     prdata_next = fg_colour_o;
            GEC_OFF_WMASK:  prdata_next = wmask_reg;
            GEC_OFF_RMASK:  prdata_next = rmask_reg;
            GEC_OFF_CMP:    prdata_next = cmp_reg;
            GEC_OFF_BMIX:   prdata_next = GEC_RST;
            GEC_OFF_FMIX:   prdata_next = GEC_RST;
            GEC_OFF_MF:     prdata_next = rb_mux(rdsel_reg);
            default:        err_next    = 1'b1;
        endcase
        if (~en_reg && paddr_i != GEC_OFF_SYSCFG) begin
            prdata_next = GEC_RST;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prdata_o  <= GEC_RST;
            pslverr_o <= 1'b0;
        end else if (setup) begin
            prdata_o  <= pwrite_i ? GEC_RST : prdata_next;
            pslverr_o <= err_next;
        end
    end

    // ================================================================
    // system configuration: the only register alive while disabled
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            en_reg <= 1'b0;
        end else if (access && pwrite_i && paddr_i == GEC_OFF_SYSCFG) begin
            en_reg <= pwdata_i[GEC_CFG_EN];
        end
    end

    // ================================================================
    // geometry registers
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dest_y_o   <= 14'h0;
            dest_x_o   <= 14'h0;
            err_term_o <= 14'h0;
            major_o    <= 12'h0;
        end else if (wr) begin
            case (paddr_i)
                GEC_OFF_DEST_Y: dest_y_o   <= pwdata_i[13:0];
                GEC_OFF_DEST_X: dest_x_o   <= pwdata_i[13:0];
                GEC_OFF_ERR:    err_term_o <= pwdata_i[13:0];
                GEC_OFF_MAJOR:  major_o    <= pwdata_i[11:0];
                default: ;
            endcase
        end
    end

    // ================================================================
    // drawing command: a write on the status address
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmd_o       <= gec_cmd_t'(16'h0);
            cmd_valid_o <= 1'b0;
        end else begin
            cmd_valid_o <= wr && paddr_i == GEC_OFF_STATUS;
            if (wr && paddr_i == GEC_OFF_STATUS) begin
                // bit 0 is passed on as written; software keeps it one
                cmd_o <= gec_cmd_t'(pwdata_i[15:0]);
            end
        end
    end

    // ================================================================
    // short-stroke vectors
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            vec1_o      <= gec_vec_t'(8'h0);
            vec2_o      <= gec_vec_t'(8'h0);
            vec_valid_o <= 1'b0;
        end else begin
            vec_valid_o <= wr && paddr_i == GEC_OFF_SSV;
            if (wr && paddr_i == GEC_OFF_SSV) begin
                vec1_o <= gec_vec_t'(pwdata_i[7:0]);
                vec2_o <= gec_vec_t'(pwdata_i[15:8]);
            end
        end
    end

    // ================================================================
    // colours, masks and mixes
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bg_colour_o <= GEC_RST;
            fg_colour_o <= GEC_RST;
            wmask_reg   <= GEC_RST;
            rmask_reg   <= GEC_RST;
            cmp_reg     <= GEC_RST;
            bg_mix_o    <= 7'h0;
            fg_mix_o    <= 7'h0;
        end else if (wr) begin
            case (paddr_i)
                GEC_OFF_BG:    bg_colour_o <= pwdata_i;
                GEC_OFF_FG:    fg_colour_o <= pwdata_i;
                GEC_OFF_WMASK: wmask_reg   <= pwdata_i;
                GEC_OFF_RMASK: rmask_reg   <= pwdata_i;
                GEC_OFF_CMP:   cmp_reg     <= pwdata_i;
                // reserved bit 4 is kept zero
                GEC_OFF_BMIX:  bg_mix_o <= {pwdata_i[6:5], 1'b0, pwdata_i[3:0]};
                GEC_OFF_FMIX:  fg_mix_o <= {pwdata_i[6:5], 1'b0, pwdata_i[3:0]};
                default: ;
            endcase
        end
    end

    // ================================================================
    // multifunction address, steered by the index nibble
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            minor_o     <= 12'h0;
            clip_top_o  <= 12'h0;
            clip_left_o <= 12'h0;
            mf_misc_o   <= 12'h0;
            rdsel_reg   <= 3'h0;
        end else if (wr && paddr_i == GEC_OFF_MF) begin
            case (pwdata_i[15:12])
                GEC_MF_MINOR: minor_o     <= pwdata_i[11:0];
                GEC_MF_TOP:   clip_top_o  <= pwdata_i[11:0];
                GEC_MF_LEFT:  clip_left_o <= pwdata_i[11:0];
                GEC_MF_MISC:  mf_misc_o   <= pwdata_i[11:0];
                GEC_MF_RDSEL: rdsel_reg   <= pwdata_i[2:0];
                default: ;
            endcase
        end
    end

    // ================================================================
    // pixel datapath, one cycle behind its inputs
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pix_wr_o    <= GEC_RST;
            pix_rd_o    <= GEC_RST;
            cmp_match_o <= 1'b0;
        end else begin
            pix_wr_o    <= (pix_new_i & wmask_reg) | (bitmap_i & ~wmask_reg);
            pix_rd_o    <= bitmap_i & rmask_reg;
            cmp_match_o <= bitmap_i == cmp_reg;
        end
    end

    // ================================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    logic rd_setup;
    assign rd_setup = setup & ~pwrite_i & en_reg;

    stat_busy_a: assert property (rd_setup && paddr_i == GEC_OFF_STATUS
        |=> prdata_o[GEC_ST_BUSY] == $past(engine_busy_i))
        else $error("busy bit wrong");
    stat_empty_a: assert property (rd_setup && paddr_i == GEC_OFF_STATUS
        |=> prdata_o[GEC_ST_EMPTY] == $past(fifo_empty_i))
        else $error("empty bit wrong");
    stat_free_a: assert property (rd_setup && paddr_i == GEC_OFF_STATUS
        |=> {prdata_o[15:11], prdata_o[7:0]} == $past(fifo_free_i))
        else $error("free count split wrong");
    cmd_skip_a: assert property (wr && paddr_i == GEC_OFF_STATUS
        |=> cmd_valid_o && cmd_o.skip_last == $past(pwdata_i[2])
        ##1 !cmd_valid_o)
        else $error("command strobe or skip bit wrong");
    cmd_fields_a: assert property (wr && paddr_i == GEC_OFF_STATUS
        |=> cmd_o.dir == $past(pwdata_i[7:5])
        && cmd_o.ctype == $past(pwdata_i[15:13])
        && cmd_o.bus_size == $past(pwdata_i[10:9]))
        else $error("command fields wrong");
    vec_split_a: assert property (wr && paddr_i == GEC_OFF_SSV
        |=> vec_valid_o && vec2_o.len_m1 == $past(pwdata_i[11:8])
        && vec1_o.dir == $past(pwdata_i[7:5]))
        else $error("short stroke split wrong");
    dest_y_a: assert property (wr && paddr_i == GEC_OFF_DEST_Y
        |=> dest_y_o == $past(pwdata_i[13:0]) ##1 $stable(dest_y_o))
        else $error("dest y not stored");
    off_hold_a: assert property (!en_reg && access && pwrite_i
        && paddr_i == GEC_OFF_FG |=> $stable(fg_colour_o))
        else $error("write taken while disabled");
    mf_steer_a: assert property (wr && paddr_i == GEC_OFF_MF
        && pwdata_i[15:12] == GEC_MF_TOP |=> $stable(minor_o)
        && clip_top_o == $past(pwdata_i[11:0]))
        else $error("multifunction steering wrong");
    rdbk_a: assert property (rd_setup && paddr_i == GEC_OFF_MF
        && rdsel_reg == GEC_RB_MINOR |=> prdata_o[11:0] == minor_o)
        else $error("read-back data wrong");
    // the mask in force is the one sampled with the pixel inputs
    wmask_a: assert property (##1 pix_wr_o == (($past(pix_new_i)
        & $past(wmask_reg)) | ($past(bitmap_i) & ~$past(wmask_reg))))
        else $error("write mask gating wrong");

    cmd_cov_c: cover property (wr && paddr_i == GEC_OFF_STATUS);
    rdbk_cov_c: cover property (wr && paddr_i == GEC_OFF_MF
        && pwdata_i[15:12] == GEC_MF_RDSEL ##[1:5] rd_setup
        && paddr_i == GEC_OFF_MF);
    off_cov_c: cover property (!en_reg && access && pwrite_i);
endmodule
`default_nettype wire

//--- inc/gec_pkg.sv
// shared constants and types of the drawing engine register bank
package gec_pkg;
    // ================================================================
    // register byte offsets
    localparam logic [15:0] GEC_OFF_DEST_Y  = 16'h8ae8;
    localparam logic [15:0] GEC_OFF_DEST_X  = 16'h8ee8;
    localparam logic [15:0] GEC_OFF_ERR     = 16'h92e8;
    localparam logic [15:0] GEC_OFF_MAJOR   = 16'h96e8;
    localparam logic [15:0] GEC_OFF_STATUS  = 16'h9ae8;
    localparam logic [15:0] GEC_OFF_SSV     = 16'h9ee8;
    localparam logic [15:0] GEC_OFF_BG      = 16'ha2e8;
    localparam logic [15:0] GEC_OFF_FG      = 16'ha6e8;
    localparam logic [15:0] GEC_OFF_WMASK   = 16'haae8;
    localparam logic [15:0] GEC_OFF_RMASK   = 16'haee8;
    localparam logic [15:0] GEC_OFF_CMP     = 16'hb2e8;
    localparam logic [15:0] GEC_OFF_BMIX    = 16'hb6e8;
    localparam logic [15:0] GEC_OFF_FMIX    = 16'hbae8;
    localparam logic [15:0] GEC_OFF_MF      = 16'hbee8;
    localparam logic [15:0] GEC_OFF_SYSCFG  = 16'h0040;
    // ================================================================
    // multifunction indices, held in write data bits 15-12
    localparam logic [3:0]  GEC_MF_MINOR    = 4'h0;
    localparam logic [3:0]  GEC_MF_TOP      = 4'h1;
    localparam logic [3:0]  GEC_MF_LEFT     = 4'h2;
    localparam logic [3:0]  GEC_MF_MISC     = 4'he;
    localparam logic [3:0]  GEC_MF_RDSEL    = 4'hf;
    // read-back selector codes
    localparam logic [2:0]  GEC_RB_MINOR    = 3'h0;
    localparam logic [2:0]  GEC_RB_TOP      = 3'h1;
    localparam logic [2:0]  GEC_RB_LEFT     = 3'h2;
    localparam logic [2:0]  GEC_RB_MISC     = 3'h3;
    localparam logic [2:0]  GEC_RB_MAJOR    = 3'h4;
    // ================================================================
    // field positions and reset value
    localparam int          GEC_ST_BUSY     = 9;
    localparam int          GEC_ST_EMPTY    = 10;
    localparam int          GEC_CFG_EN      = 0;
    localparam logic [31:0] GEC_RST         = 32'h0000_0000;
    // ================================================================
    // decoded drawing command
    typedef struct packed {
        logic [2:0] ctype;
        logic       swap;
        logic       rsvd;
        logic [1:0] bus_size;
        logic       wait_host;
        logic [2:0] dir;
        logic       draw;
        logic       radial;
        logic       skip_last;
        logic       across;
        logic       one;
    } gec_cmd_t;
    // one short-stroke vector
    typedef struct packed {
        logic [2:0] dir;
        logic       draw;
        logic [3:0] len_m1;
    } gec_vec_t;
endpackage
